// ---- core/frame_buffer_pkg.sv ----
// Behaviour
// - contents kept until write, receive, sleep, reset
// - receive during host read raises underrun
// - dynamic protection blocks receive writes only
// - auto retry frames evaluated, not stored
// - only sleep or reset clears buffer
// - link quality, energy, status appended on frame mode read
// - random read address zero is length field
// - auto crc replaces last two payload bytes
// - random byte writes modify single bytes
// - accept length plus 127 data bytes
// - independent host and baseband address counters
// - frame mode conflicts raise underrun, random none
// - underrun valid two octets after receive start
// - only length and payload stored
// - buffer spans addresses 0x00 to 0x7F
// - host frame over 127 octets raises underrun
// - access refused while asleep
package frame_buffer_pkg;
   localparam int  ADDR_W        = 7;
   localparam int  DEPTH         = 128;
   localparam logic [6:0] LAST_ADDR = 7'h7F;
   localparam logic [7:0] MAX_LEN   = 8'h7F;
   localparam logic [1:0] META_CNT  = 2'h3;
   localparam logic [1:0] VALID_OCTETS = 2'h2;
   localparam logic [3:0] REG_DATA  = 4'h0;
   localparam logic [3:0] REG_ADDR  = 4'h1;
   localparam logic [3:0] REG_CTRL  = 4'h2;
   localparam logic [3:0] REG_STAT  = 4'h3;
   localparam int  CTRL_RANDOM   = 0;
   localparam int  CTRL_PROTECT  = 1;
   localparam int  CTRL_AUTOCRC  = 2;
   localparam logic [7:0] CTRL_RESET = 8'h00;
endpackage

// ---- core/radio_frame_buffer_manager.sv ----
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/100ps
module radio_frame_buffer_manager
   import frame_buffer_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   input  wire logic       sleep,
   input  wire logic       auto_retry_transmit_state,
   input  wire logic       rx_start,
   input  wire logic       rx_valid,
   input  wire logic [7:0] rx_byte,
   input  wire logic       rx_end,
   input  wire logic [7:0] rx_lqi,
   input  wire logic [7:0] rx_ed,
   input  wire logic [7:0] rx_status,
   input  wire logic       tx_start,
   input  wire logic       tx_take,
   input  wire logic [7:0] tx_crc,
   output logic      [7:0] tx_byte,
   output logic            buffer_underrun_irq,
   output logic            buffer_empty
);
   typedef struct packed {
      logic [DEPTH-1:0][7:0] mem;
      logic [6:0] host_ptr;
      logic [6:0] bb_ptr;
      logic [7:0] wlen;
      logic [1:0] meta_idx;
      logic [7:0] lqi;
      logic [7:0] ed;
      logic [7:0] stat;
      logic [7:0] ctrl;
      logic       host_reading;
      logic       rx_active;
      logic       have_frame;
      logic [1:0] octets;
      logic       ur;
      logic [7:0] rdata;
      logic [7:0] tx_byte;
   } state_t;
   state_t r, next_r;

   function automatic logic [6:0] inc7(input logic [6:0] v);
      inc7 = v + 7'h01;
   endfunction

   logic rx_store;
   logic conflict;
   logic frame_mode;
   always_comb begin
      next_r = r;
      frame_mode = !r.ctrl[CTRL_RANDOM];
      // retry wait and protected frame keep the buffer
      rx_store = rx_valid && !auto_retry_transmit_state
                 && !(r.ctrl[CTRL_PROTECT] && r.have_frame);
      conflict = 1'b0;
      if (rx_start) begin
         next_r.octets = 2'h0;
         next_r.rx_active = 1'b1;
         next_r.bb_ptr = 7'h00;
         // new frame during host read of old one
         if (r.host_reading && frame_mode)
            conflict = 1'b1;
      end
      if (rx_store) begin
         next_r.mem[r.bb_ptr] = rx_byte;
         next_r.bb_ptr = inc7(r.bb_ptr);
         if (r.octets != VALID_OCTETS)
            next_r.octets = r.octets + 2'h1;
      end
      if (rx_end) begin
         next_r.rx_active = 1'b0;
         // a protected frame keeps its own metadata as well
         if (!auto_retry_transmit_state &&
             !(r.ctrl[CTRL_PROTECT] && r.have_frame)) begin
            next_r.lqi = rx_lqi;
            next_r.ed = rx_ed;
            next_r.stat = rx_status;
            next_r.have_frame = 1'b1;
         end
      end
      if (tx_start)
         next_r.bb_ptr = 7'h00;
      if (tx_take) begin
         // last two payload bytes replaced by computed check
         if (r.ctrl[CTRL_AUTOCRC] && r.mem[0] >= 8'h02 &&
             ({1'b0, r.bb_ptr} + 8'h02 > r.mem[0]))
            next_r.tx_byte = tx_crc;
         else
            next_r.tx_byte = r.mem[r.bb_ptr];
         next_r.bb_ptr = inc7(r.bb_ptr);
      end
      next_r.rdata = 8'h00;
      if (!sleep && wr) begin
         if (addr == REG_DATA) begin
            next_r.mem[r.host_ptr] = wdata;
            next_r.host_ptr = inc7(r.host_ptr);
            next_r.have_frame = 1'b0;
            if (frame_mode) begin
               if (r.wlen == {1'b0, LAST_ADDR} + 8'h01)
                  conflict = 1'b1;
               else
                  next_r.wlen = r.wlen + 8'h01;
            end
         end else if (addr == REG_ADDR) begin
            next_r.host_ptr = wdata[6:0];
            next_r.wlen = 8'h00;
            next_r.meta_idx = 2'h0;
            next_r.host_reading = 1'b0;
         end else if (addr == REG_CTRL) begin
            next_r.ctrl = wdata;
         end
      end else if (!sleep && rd) begin
         if (addr == REG_DATA) begin
            next_r.host_reading = frame_mode;
            // after length field plus payload, metadata follows
            if (frame_mode && r.host_ptr != 7'h00 &&
                {1'b0, r.host_ptr} > r.mem[0] && r.meta_idx != META_CNT)
            begin
               next_r.rdata = (r.meta_idx == 2'h0) ? r.lqi :
                              (r.meta_idx == 2'h1) ? r.ed : r.stat;
               next_r.meta_idx = r.meta_idx + 2'h1;
            end else begin
               next_r.rdata = r.mem[r.host_ptr];
               next_r.host_ptr = inc7(r.host_ptr);
               // host overtaking baseband writer
               if (frame_mode && r.rx_active &&
                   r.host_ptr == r.bb_ptr)
                  conflict = 1'b1;
            end
         end else if (addr == REG_ADDR) begin
            next_r.rdata = {1'b0, r.host_ptr};
         end else if (addr == REG_CTRL) begin
            next_r.rdata = r.ctrl;
         end else if (addr == REG_STAT) begin
            next_r.rdata = {6'h00, r.have_frame, r.ur};
            next_r.ur = 1'b0;
         end
      end
      // underrun masked after the receive start cycle until two octets are stored
      if (conflict && !(r.rx_active && r.octets != VALID_OCTETS
                        && !rx_start))
         next_r.ur = 1'b1;                  // set wins over status-read clear
      if (sleep) begin
         next_r = '0;
         next_r.ctrl = r.ctrl;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign rdata = r.rdata;
   assign tx_byte = r.tx_byte;
   assign buffer_underrun_irq = r.ur;
   assign buffer_empty = r.rx_active && (r.host_ptr == r.bb_ptr);

   chk_sleep_clears: assert property (@(posedge clk) disable iff (!rstn)
      sleep |=> !r.have_frame && r.host_ptr == 7'h00)
      else $error("sleep did not clear buffer");
   chk_retry_nostore: assert property (@(posedge clk) disable iff (!rstn)
      rx_valid && auto_retry_transmit_state && !sleep
      |=> r.mem[$past(r.bb_ptr)] == $past(r.mem[r.bb_ptr]))
      else $error("retry frame stored");
   chk_status_clear: assert property (@(posedge clk) disable iff (!rstn)
      rd && addr == REG_STAT && !sleep && r.ur |=> rdata[0])
      else $error("status read lost underrun");
   chk_ur_sticky: assert property (@(posedge clk) disable iff (!rstn)
      r.ur && !(rd && addr == REG_STAT) && !sleep |=> r.ur)
      else $error("underrun dropped");
   chk_random_noflag: assert property (@(posedge clk) disable iff (!rstn)
      r.ctrl[CTRL_RANDOM] && !r.ur && !(wr && addr == REG_CTRL)
      |=> !r.ur)
      else $error("underrun in random mode");
   chk_host_write: assert property (@(posedge clk) disable iff (!rstn)
      wr && addr == REG_DATA && !sleep && !rx_store
      |=> r.mem[$past(r.host_ptr)] == $past(wdata))
      else $error("host write lost");
   chk_ptr_step: assert property (@(posedge clk) disable iff (!rstn)
      rd && addr == REG_DATA && !sleep && r.ctrl[CTRL_RANDOM]
      |=> r.host_ptr == $past(r.host_ptr) + 7'h01)
      else $error("host pointer did not advance");
   chk_sleep_refuse: assert property (@(posedge clk) disable iff (!rstn)
      sleep && rd |=> rdata == 8'h00)
      else $error("access while asleep");
   // read data only ever stand in the cycle after a read
   chk_rdata_idle: assert property (@(posedge clk)
      disable iff (!rstn)
      !rd |=> rdata == 8'h00)
      else $error("read data without read");
   chk_addr_readback: assert property (@(posedge clk)
      disable iff (!rstn)
      rd && addr == REG_ADDR && !sleep |=> rdata == {1'b0, $past(r.host_ptr)})
      else $error("host pointer readback wrong");
   chk_ptr_load: assert property (@(posedge clk)
      disable iff (!rstn)
      wr && addr == REG_ADDR && !sleep |=> r.host_ptr == $past(wdata[6:0]))
      else $error("host pointer not loaded");
   chk_wr_advance: assert property (@(posedge clk)
      disable iff (!rstn)
      wr && addr == REG_DATA && !sleep |=> r.host_ptr == $past(r.host_ptr) + 7'h01)
      else $error("host pointer did not advance on write");
   chk_tx_restart: assert property (@(posedge clk)
      disable iff (!rstn)
      tx_start && !tx_take && !sleep |=> r.bb_ptr == 7'h00)
      else $error("transmit start did not rewind");
   chk_rx_restart: assert property (@(posedge clk)
      disable iff (!rstn)
      rx_start && !rx_valid && !tx_take && !sleep |=> r.bb_ptr == 7'h00)
      else $error("receive start did not rewind");
   chk_rx_store: assert property (@(posedge clk)
      disable iff (!rstn)
      rx_store && !sleep && !(wr && addr == REG_DATA)
      |=> r.mem[$past(r.bb_ptr)] == $past(rx_byte))
      else $error("received byte not stored");
   chk_rx_advance: assert property (@(posedge clk)
      disable iff (!rstn)
      rx_store && !tx_start && !tx_take && !sleep
      |=> r.bb_ptr == $past(r.bb_ptr) + 7'h01)
      else $error("baseband pointer did not advance");
   chk_meta_capture: assert property (@(posedge clk)
      disable iff (!rstn)
      rx_end && !auto_retry_transmit_state && !sleep
      && !(r.ctrl[CTRL_PROTECT] && r.have_frame)
      |=> r.lqi == $past(rx_lqi) && r.ed == $past(rx_ed)
          && r.stat == $past(rx_status))
      else $error("frame metadata not captured");
   chk_retry_meta: assert property (@(posedge clk)
      disable iff (!rstn)
      rx_end && auto_retry_transmit_state && !sleep |=> $stable(r.lqi))
      else $error("retry frame metadata stored");
   // dropping bytes is the whole point of protection, so watch all of it
   chk_protect_hold: assert property (@(posedge clk)
      disable iff (!rstn)
      rx_valid && r.ctrl[CTRL_PROTECT] && r.have_frame && !sleep
      && !(wr && addr == REG_DATA) |=> $stable(r.mem))
      else $error("protected frame overwritten");
   chk_overflow_flag: assert property (@(posedge clk)
      disable iff (!rstn)
      wr && addr == REG_DATA && !sleep && !r.ctrl[CTRL_RANDOM]
      && !r.rx_active && r.wlen == {1'b0, LAST_ADDR} + 8'h01 |=> r.ur)
      else $error("overlong frame not flagged");
   chk_ur_masked: assert property (@(posedge clk)
      disable iff (!rstn)
      r.rx_active && r.octets != VALID_OCTETS && !rx_start && !r.ur
      |=> !r.ur)
      else $error("underrun raised too early");
   chk_rx_overrun: assert property (@(posedge clk)
      disable iff (!rstn)
      rx_start && r.host_reading && !r.ctrl[CTRL_RANDOM] && !sleep
      |=> r.ur)
      else $error("frame over unread frame not flagged");
   chk_tx_crc: assert property (@(posedge clk)
      disable iff (!rstn)
      tx_take && !sleep && r.ctrl[CTRL_AUTOCRC] && r.mem[0] >= 8'h02
      && ({1'b0, r.bb_ptr} + 8'h02 > r.mem[0]) |=> tx_byte == $past(tx_crc))
      else $error("check bytes not replaced");
   chk_tx_plain: assert property (@(posedge clk)
      disable iff (!rstn)
      tx_take && !sleep && !r.ctrl[CTRL_AUTOCRC]
      |=> tx_byte == $past(r.mem[r.bb_ptr]))
      else $error("transmit byte wrong");
   chk_sleep_ctrl: assert property (@(posedge clk)
      disable iff (!rstn)
      sleep |=> r.ctrl == $past(r.ctrl))
      else $error("control lost in sleep");
   chk_len_first: assert property (@(posedge clk)
      disable iff (!rstn)
      rd && addr == REG_DATA && !sleep && r.host_ptr == 7'h00
      |=> rdata == $past(r.mem[0]))
      else $error("length field not at address zero");
   cov_overflow: cover property (@(posedge clk) disable iff (!rstn)
      wr && addr == REG_DATA && r.wlen == {1'b0, LAST_ADDR} + 8'h01);
   cov_meta_read: cover property (@(posedge clk) disable iff (!rstn)
      rd && addr == REG_DATA && r.meta_idx == 2'h2);
   cov_rx_frame: cover property (@(posedge clk) disable iff (!rstn)
      rx_start ##[1:40] rx_end);
   cov_underrun: cover property (@(posedge clk) disable iff (!rstn)
      $rose(r.ur));
   cov_tx: cover property (@(posedge clk) disable iff (!rstn)
      tx_start ##[1:20] tx_take);
endmodule // radio_frame_buffer_manager

// ---- sim/baseband_model.sv ----
`timescale 1ns/100ps
module baseband_model (
   input  wire logic       clk,
   output logic            rx_start,
   output logic            rx_valid,
   output logic      [7:0] rx_byte,
   output logic            rx_end,
   output logic      [7:0] rx_lqi,
   output logic      [7:0] rx_ed,
   output logic      [7:0] rx_status
);
   initial begin
      {rx_start, rx_valid, rx_end} = 3'h0;
      {rx_byte, rx_lqi, rx_ed, rx_status} = 32'h0;
   end
   // only length and payload cross, the sync header stays internal
   task automatic rx_frame(input logic [7:0] len, first, lqi, ed, st);
      @(posedge clk) rx_start <= 1'b1;
      @(posedge clk) rx_start <= 1'b0;
      for (int i = 0; i <= len; i++) begin
         @(posedge clk) rx_valid <= 1'b1;
         rx_byte <= (i == 0) ? len : first + 8'(i - 1);
         @(posedge clk) rx_valid <= 1'b0;
         rx_byte <= ~rx_byte;
      end
      @(posedge clk) rx_end <= 1'b1;
      {rx_lqi, rx_ed, rx_status} <= {lqi, ed, st};
      @(posedge clk) rx_end <= 1'b0;
      {rx_lqi, rx_ed, rx_status} <= ~{lqi, ed, st};
   endtask
endmodule // baseband_model

// ---- sim/tb.sv ----
`timescale 1ns/100ps
module tb;
   import frame_buffer_pkg::*;
   logic       clk, rstn, wr, rd, sleep, art, tx_start, tx_take;
   logic [3:0] addr;
   logic [7:0] wdata, tx_crc, rdata, tx_byte, rx_byte, lqi, ed, st;
   logic       rx_start, rx_valid, rx_end, irq, empty;
   int         failures, checked, cycles;
   radio_frame_buffer_manager radio_frame_buffer_manager_i (.clk(clk),
      .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .sleep(sleep), .auto_retry_transmit_state(art),
      .rx_start(rx_start), .rx_valid(rx_valid), .rx_byte(rx_byte),
      .rx_end(rx_end), .rx_lqi(lqi), .rx_ed(ed), .rx_status(st),
      .tx_start(tx_start), .tx_take(tx_take), .tx_crc(tx_crc),
      .tx_byte(tx_byte), .buffer_underrun_irq(irq), .buffer_empty(empty));
   baseband_model baseband_model_i (.clk(clk), .rx_start(rx_start),
      .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_end(rx_end),
      .rx_lqi(lqi), .rx_ed(ed), .rx_status(st));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic results();
      if (failures == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic cmp(input logic [7:0] got, exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk) {wr, addr, wdata} <= {1'b1, a, d};
      @(posedge clk) wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e, m);
      @(posedge clk) {rd, addr} <= {1'b1, a};
      @(posedge clk) rd <= 1'b0;
      @(negedge clk) cmp(rdata & m, e);
   endtask
   task automatic rd_frame(input logic [7:0] b[$]);
      wr_reg(REG_ADDR, 8'h00);
      foreach (b[i]) rd_chk(REG_DATA, b[i], 8'hFF);
   endtask
   task automatic tx_chk(input logic [7:0] b[$]);
      @(posedge clk) tx_start <= 1'b1;
      @(posedge clk) tx_start <= 1'b0;
      foreach (b[i]) begin
         @(posedge clk) tx_take <= 1'b1;
         @(posedge clk) tx_take <= 1'b0;
         @(negedge clk) cmp(tx_byte, b[i]);
      end
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 8000) begin
         failures++;
         results();
      end
   end
   initial begin
      {rstn, wr, rd, sleep, art, tx_start, tx_take} = 7'h0;
      {addr, wdata, tx_crc} = 20'h0;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      rd_chk(REG_CTRL, CTRL_RESET, 8'hFF);
      rd_chk(REG_STAT, 8'h00, 8'h01);
      wr_reg(REG_ADDR, 8'h00);
      wr_reg(REG_DATA, 8'h03);
      wr_reg(REG_DATA, 8'h11);
      wr_reg(REG_DATA, 8'h1F);
      wr_reg(REG_DATA, 8'h2D);
      rd_frame('{8'h03, 8'h11, 8'h1F, 8'h2D});
      wr_reg(REG_CTRL, 8'h01);
      wr_reg(REG_ADDR, 8'h02);
      wr_reg(REG_DATA, 8'h5A);
      rd_chk(REG_DATA, 8'h2D, 8'hFF);
      wr_reg(REG_CTRL, 8'h00);
      rd_frame('{8'h03, 8'h11, 8'h5A, 8'h2D});
      tx_chk('{8'h03, 8'h11, 8'h5A, 8'h2D});
      tx_crc <= 8'hC3;
      wr_reg(REG_CTRL, 8'h04);
      tx_chk('{8'h03, 8'h11, 8'hC3, 8'hC3});
      wr_reg(REG_CTRL, 8'h00);
      wr_reg(REG_ADDR, 8'h00);
      rd_chk(REG_DATA, 8'h03, 8'hFF);
      // host one byte in: empty once the baseband has stored the length
      fork
         baseband_model_i.rx_frame(8'h01, 8'hA1, 8'h44, 8'h55, 8'h66);
         begin
            repeat (4) @(posedge clk);
            @(negedge clk) cmp({7'h00, empty}, 8'h01);
         end
      join
      rd_frame('{8'h01, 8'hA1, 8'h44, 8'h55, 8'h66});
      art <= 1'b1;
      baseband_model_i.rx_frame(8'h02, 8'hB0, 8'h77, 8'h88, 8'h99);
      art <= 1'b0;
      rd_frame('{8'h01, 8'hA1, 8'h44, 8'h55, 8'h66});
      wr_reg(REG_CTRL, 8'h02);
      baseband_model_i.rx_frame(8'h02, 8'hC0, 8'h12, 8'h34, 8'h56);
      rd_frame('{8'h01, 8'hA1, 8'h44, 8'h55, 8'h66});
      wr_reg(REG_CTRL, 8'h00);
      rd_chk(REG_STAT, 8'h03, 8'h03);
      wr_reg(REG_ADDR, 8'h00);
      repeat (128) wr_reg(REG_DATA, 8'h0F);
      rd_chk(REG_STAT, 8'h00, 8'h01);
      wr_reg(REG_DATA, 8'h0F);
      rd_chk(REG_STAT, 8'h01, 8'h01);
      rd_chk(REG_STAT, 8'h00, 8'h01);
      sleep <= 1'b1;
      rd_chk(REG_DATA, 8'h00, 8'hFF);
      sleep <= 1'b0;
      rd_frame('{8'h00, 8'h00});
      results();
   end
endmodule // tb
